// ---- logic/mmb_pkg.sv ----
// Purpose: Shared constants and types for the measurement min/max register bank.
// Assumes: Byte-wide register port driven by the serial protocol engine.
// Notes:   Offsets are byte addresses as seen by the host.
`default_nettype none

package mmb_pkg;

   // ------------------------------------------------------------------
   // Port widths and quantity count
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RESULT_W = 16;
   localparam int unsigned QTY_COUNT = 4;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_NV_TIMEBASE_DIVIDE = 8'h30;
   localparam logic [7:0] OFF_NV_CURRENT_LIMIT_TRIM = 8'h31;
   localparam logic [7:0] OFF_RESERVED_HI = 8'h32;
   localparam logic [7:0] OFF_RESERVED_LO = 8'h33;
   localparam logic [7:0] OFF_GPIO_LATEST = 8'h34;
   localparam logic [7:0] OFF_GPIO_LOWEST = 8'h36;
   localparam logic [7:0] OFF_GPIO_HIGHEST = 8'h38;
   localparam logic [7:0] OFF_SOURCE_LATEST = 8'h3A;
   localparam logic [7:0] OFF_SOURCE_LOWEST = 8'h3C;
   localparam logic [7:0] OFF_SOURCE_HIGHEST = 8'h3E;
   localparam logic [7:0] OFF_SHUNT_LATEST = 8'h40;
   localparam logic [7:0] OFF_SHUNT_LOWEST = 8'h42;
   localparam logic [7:0] OFF_SHUNT_HIGHEST = 8'h44;
   localparam logic [7:0] OFF_POWER_LATEST = 8'h46;
   localparam logic [7:0] OFF_POWER_LOWEST = 8'h48;
   localparam logic [7:0] OFF_POWER_HIGHEST = 8'h4A;

   // Each quantity spans latest, lowest and highest pairs
   localparam logic [7:0] PAIR_SPAN = OFF_SOURCE_LATEST - OFF_GPIO_LATEST;
   localparam logic [7:0] QTY_BASE [QTY_COUNT] = '{
      OFF_GPIO_LATEST, OFF_SOURCE_LATEST, OFF_SHUNT_LATEST, OFF_POWER_LATEST};

   // ------------------------------------------------------------------
   // Reset values and fixed read values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_NV_TIMEBASE_DIVIDE = 8'h08;
   localparam logic [7:0] RST_NV_CURRENT_LIMIT_TRIM = 8'h96;
   localparam logic [7:0] RESERVED_VALUE = 8'h00;
   localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
   localparam logic [15:0] RST_LATEST = 16'h0000;
   localparam logic [15:0] RST_LOWEST = 16'hFFFF;
   localparam logic [15:0] RST_HIGHEST = 16'h0000;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SLOT_LATEST,
      SLOT_LOWEST,
      SLOT_HIGHEST
   } mmb_slot_e;

   typedef struct packed {
      logic hit;
      logic [1:0] qty;
      mmb_slot_e slot;
      logic lowByte;
   } mmb_dec_s;

endpackage

`default_nettype wire

// ---- logic/mmb_minmax_track.sv ----
// Purpose: Latest, lowest and highest tracking for one measured quantity.
// Assumes: One sample pulse per conversion; host writes arrive as whole words.
// Notes:   A host write wins over a conversion landing in the same cycle.
`timescale 1ns/1ns
`default_nettype none

module mmb_minmax_track #(
   parameter int unsigned WIDTH = 16,
   parameter logic [WIDTH-1:0] LATEST_INIT = '0,
   parameter logic [WIDTH-1:0] LOWEST_INIT = '1,
   parameter logic [WIDTH-1:0] HIGHEST_INIT = '0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sampleValid,
   input wire logic [WIDTH-1:0] sampleValue,
   input wire logic wrLatest,
   input wire logic wrLowest,
   input wire logic wrHighest,
   input wire logic [WIDTH-1:0] wrValue,
   output logic [WIDTH-1:0] latest,
   output logic [WIDTH-1:0] lowest,
   output logic [WIDTH-1:0] highest
);

   // --------------------------------------------------------------
   // Elaboration check
   // --------------------------------------------------------------
   if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("mmb_minmax_track: WIDTH must be 1 to 32");
   end

   // Latest result; whole word at once so halves never mix
   always_ff @(posedge mclk) begin
      if (rst) begin
         latest <= LATEST_INIT;
      end else if (wrLatest) begin
         latest <= wrValue;
      end else if (sampleValid) begin
         latest <= sampleValue;
      end
   end

   // Smallest seen; compare against whatever is stored, written or not
   always_ff @(posedge mclk) begin
      if (rst) begin
         lowest <= LOWEST_INIT;
      end else if (wrLowest) begin
         lowest <= wrValue;
      end else if (sampleValid && sampleValue < lowest) begin
         lowest <= sampleValue;
      end
   end

   // Largest seen; equal values leave it alone
   always_ff @(posedge mclk) begin
      if (rst) begin
         highest <= HIGHEST_INIT;
      end else if (wrHighest) begin
         highest <= wrValue;
      end else if (sampleValid && sampleValue > highest) begin
         highest <= sampleValue;
      end
   end

endmodule

`default_nettype wire

// ---- logic/mmb_register_bank.sv ----
// Purpose: Monitoring result bank with min/max tracking and two default bytes.
// Assumes: Protocol engine presents one byte access per strobe, in mclk domain.
// Notes:   Pairs are read and written atomically through shadow and hold bytes.
//
// What this block does
// - Default timebase divider byte, factory 0x08
// - Default current limit trim byte, factory 96h
// - Bytes 0x32 and 0x33 read zero
// - Latest GPIO voltage result at 0x34/0x35
// - Lowest GPIO voltage result at 0x36/0x37
// - Highest GPIO voltage result at 0x38/0x39
// - Latest source voltage result at 0x3A/0x3B
// - Lowest source voltage result at 0x3C/0x3D
// - Highest source voltage result at 0x3E/0x3F
// - Latest shunt voltage result at 0x40/0x41
// - Lowest shunt voltage result at 0x42/0x43
// - Highest shunt voltage result at 0x44/0x45
// - Latest power at 0x46/0x47, host writable
// - Lowest power result at 0x48/0x49
// - Highest power result at 0x4A/0x4B
`timescale 1ns/1ns
`default_nettype none

module mmb_register_bank (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [mmb_pkg::ADDR_W-1:0] regAddr,
   input wire logic regWrStrobe,
   input wire logic [mmb_pkg::DATA_W-1:0] regWrData,
   input wire logic regRdStrobe,
   output logic [mmb_pkg::DATA_W-1:0] regRdData,
   output logic regRdValid,
   output logic regWrAck,
   output logic regAddrError,
   input wire logic gpioConvValid,
   input wire logic [mmb_pkg::RESULT_W-1:0] gpioConvValue,
   input wire logic sourceConvValid,
   input wire logic [mmb_pkg::RESULT_W-1:0] sourceConvValue,
   input wire logic shuntConvValid,
   input wire logic [mmb_pkg::RESULT_W-1:0] shuntConvValue,
   input wire logic powerConvValid,
   input wire logic [mmb_pkg::RESULT_W-1:0] powerConvValue,
   output logic [mmb_pkg::DATA_W-1:0] timebaseDivideDefault,
   output logic [mmb_pkg::DATA_W-1:0] currentLimitTrimDefault
);
   import mmb_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------

   // Byte lanes are hard-wired as the high and low halves of a result
   if (RESULT_W != 2 * DATA_W) begin : g_bad_result_width
      $error("mmb_register_bank: RESULT_W must be twice DATA_W");
   end

   // The gather below names exactly four conversion ports
   if (QTY_COUNT != 4) begin : g_bad_qty_count
      $error("mmb_register_bank: QTY_COUNT must be 4");
   end

   // Decode splits each quantity into latest, lowest and highest pairs
   if (PAIR_SPAN != 8'h06) begin : g_bad_pair_span
      $error("mmb_register_bank: each quantity must span three pairs");
   end

   // ------------------------------------------------------------------
   // Address decoding
   // ------------------------------------------------------------------

   // Map a byte address onto quantity, slot and byte half
   function automatic mmb_dec_s mmbDecode(input logic [7:0] addr);
      mmb_dec_s d;
      logic [7:0] rem;
      d.hit = 1'b0;
      d.qty = 2'b00;
      d.slot = SLOT_LATEST;
      d.lowByte = 1'b0;
      rem = 8'h00;
      for (int q = 0; q < QTY_COUNT; q++) begin
         if (addr >= QTY_BASE[q] && {1'b0, addr} < {1'b0, QTY_BASE[q]} + {1'b0, PAIR_SPAN}) begin
            rem = addr - QTY_BASE[q];
            d.hit = 1'b1;
            d.qty = 2'(q);
            d.slot = mmb_slot_e'(rem[2:1]);
            d.lowByte = rem[0];
         end
      end
      return d;
   endfunction

   mmb_dec_s dec;
   logic isNvTimebase;
   logic isNvTrim;
   logic isReserved;
   logic isMapped;

   // Decode the presented address once for read and write paths
   always_comb begin
      dec = mmbDecode(regAddr);
      isNvTimebase = (regAddr == OFF_NV_TIMEBASE_DIVIDE);
      isNvTrim = (regAddr == OFF_NV_CURRENT_LIMIT_TRIM);
      isReserved = (regAddr == OFF_RESERVED_HI) || (regAddr == OFF_RESERVED_LO);
      isMapped = dec.hit || isNvTimebase || isNvTrim || isReserved;
   end

   // ------------------------------------------------------------------
   // Result trackers, one per quantity
   // ------------------------------------------------------------------
   logic [RESULT_W-1:0] convValue [QTY_COUNT];
   logic [QTY_COUNT-1:0] convValid;
   logic [RESULT_W-1:0] latestArr [QTY_COUNT];
   logic [RESULT_W-1:0] lowestArr [QTY_COUNT];
   logic [RESULT_W-1:0] highestArr [QTY_COUNT];
   logic [QTY_COUNT-1:0] wrLatest;
   logic [QTY_COUNT-1:0] wrLowest;
   logic [QTY_COUNT-1:0] wrHighest;
   logic [RESULT_W-1:0] wrValue;

   // Gather the separate conversion ports in address order
   always_comb begin
      convValue[0] = gpioConvValue;
      convValue[1] = sourceConvValue;
      convValue[2] = shuntConvValue;
      convValue[3] = powerConvValue;
      convValid = {powerConvValid, shuntConvValid, sourceConvValid, gpioConvValid};
   end

   // GPIO, source, shunt and power trackers at their quantity bases
   for (genvar q = 0; q < QTY_COUNT; q++) begin : g_track
      mmb_minmax_track #(
         .WIDTH(RESULT_W),
         .LATEST_INIT(RST_LATEST),
         .LOWEST_INIT(RST_LOWEST),
         .HIGHEST_INIT(RST_HIGHEST)
      ) u_track (
         .mclk(mclk),
         .rst(rst),
         .sampleValid(convValid[q]),
         .sampleValue(convValue[q]),
         .wrLatest(wrLatest[q]),
         .wrLowest(wrLowest[q]),
         .wrHighest(wrHighest[q]),
         .wrValue(wrValue),
         .latest(latestArr[q]),
         .lowest(lowestArr[q]),
         .highest(highestArr[q])
      );
   end

   // Live 16-bit value of the pair that the address falls in
   logic [RESULT_W-1:0] pairValue;

   always_comb begin
      pairValue = '0;
      if (dec.hit) begin
         case (dec.slot)
            SLOT_LATEST: pairValue = latestArr[dec.qty];
            SLOT_LOWEST: pairValue = lowestArr[dec.qty];
            SLOT_HIGHEST: pairValue = highestArr[dec.qty];
            default: pairValue = '0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Nonvolatile default bytes
   // ------------------------------------------------------------------

   // Held in flops here; reset reloads the factory values, host writes to 0x30/0x31 load new ones
   always_ff @(posedge mclk) begin
      if (rst) begin
         timebaseDivideDefault <= RST_NV_TIMEBASE_DIVIDE;
         currentLimitTrimDefault <= RST_NV_CURRENT_LIMIT_TRIM;
      end else if (regWrStrobe) begin
         if (isNvTimebase) begin
            timebaseDivideDefault <= regWrData;
         end
         if (isNvTrim) begin
            currentLimitTrimDefault <= regWrData;
         end
      end
   end

   // ------------------------------------------------------------------
   // Write path with high-byte hold
   // ------------------------------------------------------------------
   logic holdValid_reg;
   logic [7:0] holdAddr_reg;
   logic [7:0] holdByte_reg;
   logic holdMatch;
   logic commitPair;

   // High byte waits here so a high-then-low write never lands half old, half new
   always_ff @(posedge mclk) begin
      if (rst) begin
         holdValid_reg <= 1'b0;
         holdAddr_reg <= 8'h00;
         holdByte_reg <= 8'h00;
      end else if (regWrStrobe && dec.hit) begin
         if (!dec.lowByte) begin
            holdValid_reg <= 1'b1;
            holdAddr_reg <= 8'(regAddr + 8'h01);
            holdByte_reg <= regWrData;
         end else begin
            holdValid_reg <= 1'b0;
         end
      end
   end

   // Low byte write commits the whole word; lone high byte does nothing
   always_comb begin
      holdMatch = holdValid_reg && (holdAddr_reg == regAddr);
      commitPair = regWrStrobe && dec.hit && dec.lowByte;
      wrValue = holdMatch ? {holdByte_reg, regWrData} : {pairValue[15:8], regWrData};
      wrLatest = '0;
      wrLowest = '0;
      wrHighest = '0;
      if (commitPair) begin
         case (dec.slot)
            SLOT_LATEST: wrLatest[dec.qty] = 1'b1;
            SLOT_LOWEST: wrLowest[dec.qty] = 1'b1;
            SLOT_HIGHEST: wrHighest[dec.qty] = 1'b1;
            default: wrLatest = '0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Read path with low-byte shadow
   // ------------------------------------------------------------------
   logic shadowValid_reg;
   logic [7:0] shadowAddr_reg;
   logic [7:0] shadowByte_reg;
   logic [DATA_W-1:0] rdData_next;

   // Reading a high byte freezes its low byte against later conversions
   always_ff @(posedge mclk) begin
      if (rst) begin
         shadowValid_reg <= 1'b0;
         shadowAddr_reg <= 8'h00;
         shadowByte_reg <= 8'h00;
      end else if (regRdStrobe && dec.hit) begin
         if (!dec.lowByte) begin
            shadowValid_reg <= 1'b1;
            shadowAddr_reg <= 8'(regAddr + 8'h01);
            shadowByte_reg <= pairValue[7:0];
         end else begin
            shadowValid_reg <= 1'b0;
         end
      end
   end

   // Byte selection; unmapped addresses belong to other groups, read zero
   always_comb begin
      rdData_next = UNMAPPED_VALUE;
      if (isNvTimebase) begin
         rdData_next = timebaseDivideDefault;
      end else if (isNvTrim) begin
         rdData_next = currentLimitTrimDefault;
      end else if (isReserved) begin
         rdData_next = RESERVED_VALUE;
      end else if (dec.hit && !dec.lowByte) begin
         rdData_next = pairValue[15:8];
      end else if (dec.hit && shadowValid_reg && shadowAddr_reg == regAddr) begin
         rdData_next = shadowByte_reg;
      end else if (dec.hit) begin
         rdData_next = pairValue[7:0];
      end
   end

   // Read answer one edge after the strobe; data holds until next read
   always_ff @(posedge mclk) begin
      if (rst) begin
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdStrobe;
         if (regRdStrobe) begin
            regRdData <= rdData_next;
         end
      end
   end

   // ------------------------------------------------------------------
   // Access status pulses
   // ------------------------------------------------------------------

   // Ack every write; flag unmapped reads/writes and reserved writes
   always_ff @(posedge mclk) begin
      if (rst) begin
         regWrAck <= 1'b0;
         regAddrError <= 1'b0;
      end else begin
         regWrAck <= regWrStrobe;
         regAddrError <= ((regWrStrobe || regRdStrobe) && !isMapped)
                         || (regWrStrobe && isReserved);
      end
   end

endmodule

`default_nettype wire

// ---- testbench/mmb_register_bank_chk.sv ----
// Purpose: Port assertions for the register bank
// Assumes: Single mclk domain, sync reset
// Notes:   Pair contents are judged by bench reads
`timescale 1ns/1ns
`default_nettype none
module mmb_register_bank_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic regWrStrobe,
   input wire logic [7:0] regWrData,
   input wire logic regRdStrobe,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic regAddrError,
   input wire logic [7:0] timebaseDivideDefault,
   input wire logic [7:0] currentLimitTrimDefault
);
   import mmb_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Factory bytes seen right after reset
   nv_factory_a: assert property ($fell(rst) |-> timebaseDivideDefault == 8'h08
      && currentLimitTrimDefault == 8'h96) else $error("default bytes wrong after reset");
   nv_write_a: assert property (regWrStrobe && regAddr == 8'h30
      |=> timebaseDivideDefault == $past(regWrData)) else $error("timebase byte missed");
   trim_write_a: assert property (regWrStrobe && regAddr == 8'h31 ##1 1
      |-> currentLimitTrimDefault == $past(regWrData)) else $error("trim byte missed");
   // Same-cycle write must not leak into the read
   nv_read_a: assert property (regRdStrobe && regAddr == 8'h30 |=> regRdValid
      && regRdData == $past(timebaseDivideDefault)) else $error("timebase read wrong");
   rsvd_read_a: assert property (regRdStrobe && regAddr inside {8'h32, 8'h33}
      |=> regRdValid && regRdData == 8'h00) else $error("reserved read not zero");
   rsvd_write_a: assert property (regWrStrobe && regAddr inside {8'h32, 8'h33}
      |=> regAddrError) else $error("reserved write not refused");
   map_ok_a: assert property ((regRdStrobe || regWrStrobe) && regAddr inside {[8'h30:8'h4B]}
      && !(regWrStrobe && regAddr inside {8'h32, 8'h33}) |=> !regAddrError)
      else $error("mapped access flagged");
   // Read data must not drift between reads
   rd_hold_a: assert property (!regRdStrobe |=> $stable(regRdData))
      else $error("read data moved without a read");
   rd_pulse_a: assert property (regRdValid |-> $past(regRdStrobe))
      else $error("read valid without a strobe");
endmodule
`default_nettype wire

// ---- testbench/mmb_host_model.sv ----
// Purpose: Host side of the byte register port
// Assumes: One access per call, one-cycle strobes
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module mmb_host_model (
   input wire logic mclk,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic regWrAck,
   input wire logic regAddrError,
   output logic [7:0] regAddr,
   output logic regWrStrobe,
   output logic [7:0] regWrData,
   output logic regRdStrobe
);
   import mmb_pkg::*;
   // Quiet bus until the first access
   initial begin
      regAddr = 8'h00;
      regWrStrobe = 1'b0;
      regWrData = 8'h00;
      regRdStrobe = 1'b0;
   end
   // Write a byte; f = {ack, error}
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] f);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge mclk);
      regWrStrobe <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
      @(negedge mclk);
      f = {regWrAck, regAddrError};
   endtask
   // Read a byte; f = {valid, error}, answer sampled mid-cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] f);
      @(posedge mclk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge mclk);
      regRdStrobe <= 1'b0;
      regAddr <= ~a;
      @(negedge mclk);
      d = regRdData;
      f = {regRdValid, regAddrError};
   endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives the byte port
// Notes:   Each task drives and judges one scenario
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import mmb_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] cv = 4'h0;
   logic [15:0] cval [4] = '{default: 16'h0000};
   wire logic [7:0] regAddr, regWrData, regRdData, tbDef, trimDef;
   wire logic regWrStrobe, regRdStrobe, regRdValid, regWrAck, regAddrError;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [7:0] b;
   logic [1:0] f;
   // 25 MHz
   always #20 mclk = ~mclk;
   mmb_register_bank dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
      .regWrStrobe(regWrStrobe), .regWrData(regWrData), .regRdStrobe(regRdStrobe),
      .regRdData(regRdData), .regRdValid(regRdValid), .regWrAck(regWrAck),
      .regAddrError(regAddrError), .gpioConvValid(cv[0]), .gpioConvValue(cval[0]),
      .sourceConvValid(cv[1]), .sourceConvValue(cval[1]), .shuntConvValid(cv[2]),
      .shuntConvValue(cval[2]), .powerConvValid(cv[3]), .powerConvValue(cval[3]),
      .timebaseDivideDefault(tbDef), .currentLimitTrimDefault(trimDef));
   mmb_host_model host (.mclk(mclk), .regRdData(regRdData), .regRdValid(regRdValid),
      .regWrAck(regWrAck), .regAddrError(regAddrError), .regAddr(regAddr),
      .regWrStrobe(regWrStrobe), .regWrData(regWrData), .regRdStrobe(regRdStrobe));
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles used
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   // High byte first so the low byte comes from the same word
   task automatic pair(input logic [7:0] a, input logic [15:0] e, input string n);
      logic [7:0] h;
      host.rd(a, h, f);
      host.rd(a + 8'h01, b, f);
      chk(n, e, {h, b});
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      host.wr(a, v[15:8], f);
      host.wr(a + 8'h01, v[7:0], f);
   endtask
   // One conversion pulse; value line inverted once released
   task automatic conv(input int q, input logic [15:0] v);
      @(posedge mclk);
      cv[q] <= 1'b1;
      cval[q] <= v;
      @(posedge mclk);
      cv[q] <= 1'b0;
      cval[q] <= ~v;
   endtask
   task automatic t_reset();
      chk("timebase port", 16'h0896, {tbDef, trimDef});
      pair(OFF_NV_TIMEBASE_DIVIDE, 16'h0896, "default bytes");
      for (int q = 0; q < 4; q++) begin
         pair(QTY_BASE[q], 16'h0000, "latest");
         pair(QTY_BASE[q] + 8'h02, 16'hFFFF, "lowest");
         pair(QTY_BASE[q] + 8'h04, 16'h0000, "highest");
      end
   endtask
   task automatic t_track();
      for (int q = 0; q < 4; q++) begin
         conv(q, 16'h1234);
         conv(q, 16'h0100);
         conv(q, 16'hFFFF);
         conv(q, 16'h0800 + 16'(q));
         pair(QTY_BASE[q], 16'h0800 + 16'(q), "latest");
         pair(QTY_BASE[q] + 8'h02, 16'h0100, "lowest");
         pair(QTY_BASE[q] + 8'h04, 16'hFFFF, "highest");
      end
   endtask
   task automatic t_rewrite();
      wr16(OFF_POWER_LOWEST, 16'h0050);
      pair(OFF_POWER_LOWEST, 16'h0050, "power lowest");
      conv(3, 16'h0060);
      pair(OFF_POWER_LOWEST, 16'h0050, "power lowest");
      conv(3, 16'h0040);
      pair(OFF_POWER_LOWEST, 16'h0040, "power lowest");
      wr16(OFF_GPIO_HIGHEST, 16'h0000);
      conv(0, 16'h0005);
      pair(OFF_GPIO_HIGHEST, 16'h0005, "gpio highest");
      wr16(OFF_POWER_LATEST, 16'hABCD);
      pair(OFF_POWER_LATEST, 16'hABCD, "power latest");
   endtask
   task automatic t_atomic();
      conv(0, 16'h1122);
      host.rd(OFF_GPIO_LATEST, b, f);
      chk("gpio high byte", 16'h0011, {8'h00, b});
      conv(0, 16'h3344);
      host.rd(OFF_GPIO_LATEST + 8'h01, b, f);
      chk("gpio frozen low", 16'h0022, {8'h00, b});
      host.rd(OFF_GPIO_LATEST + 8'h01, b, f);
      chk("gpio live low", 16'h0044, {8'h00, b});
      host.wr(OFF_SOURCE_LATEST, 8'h77, f);
      pair(OFF_SOURCE_LATEST, 16'h0801, "lone high write");
   endtask
   task automatic t_refuse();
      host.rd(OFF_RESERVED_HI, b, f);
      chk("reserved read", 16'h0200, {6'h00, f, b});
      host.wr(OFF_RESERVED_LO, 8'hFF, f);
      chk("reserved write", 16'h0003, {14'h0000, f});
      host.rd(OFF_RESERVED_LO, b, f);
      chk("reserved read", 16'h0200, {6'h00, f, b});
      host.rd(8'h4C, b, f);
      chk("unmapped read", 16'h0300, {6'h00, f, b});
      host.wr(OFF_NV_TIMEBASE_DIVIDE, 8'h5A, f);
      host.wr(OFF_NV_CURRENT_LIMIT_TRIM, 8'hA5, f);
      chk("timebase port", 16'h5AA5, {tbDef, trimDef});
      pair(OFF_NV_TIMEBASE_DIVIDE, 16'h5AA5, "default bytes");
   endtask
   // Lone low byte keeps stored high byte; write beats a same-edge conversion
   task automatic t_collide();
      fork
         host.wr(OFF_SHUNT_LOWEST + 8'h01, 8'h80, f);
         conv(2, 16'h0010);
      join
      pair(OFF_SHUNT_LOWEST, 16'h0180, "shunt lowest");
      pair(OFF_SHUNT_LATEST, 16'h0010, "shunt latest");
      conv(2, 16'h0150);
      pair(OFF_SHUNT_LOWEST, 16'h0150, "shunt lowest");
   endtask
   // Second reset mid-run brings back factory bytes and empty trackers
   task automatic t_midreset();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk("timebase port", 16'h0896, {tbDef, trimDef});
      pair(OFF_SHUNT_LOWEST, 16'hFFFF, "shunt lowest");
      pair(OFF_POWER_HIGHEST, 16'h0000, "power highest");
   endtask
   // Reset for 8 cycles, then the scenarios in order
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_track();
      t_rewrite();
      t_atomic();
      t_refuse();
      t_collide();
      t_midreset();
      conclude();
   end
endmodule
bind mmb_register_bank mmb_register_bank_chk chk (.mclk(mclk), .rst(rst), .regAddr(regAddr),
   .regWrStrobe(regWrStrobe), .regWrData(regWrData), .regRdStrobe(regRdStrobe),
   .regRdData(regRdData), .regRdValid(regRdValid), .regAddrError(regAddrError),
   .timebaseDivideDefault(timebaseDivideDefault),
   .currentLimitTrimDefault(currentLimitTrimDefault));
`default_nettype wire
